// *** prc_mem_end.sv ***
// memory-side reset, sleep and self-refresh control
// Functional notes
// - reset pin low returns device to standby
// - hardware reset restores configuration defaults
// - self-refresh halts while reset low
// - hardware reset exits hybrid sleep
// - hardware reset exits deep power down
// - refresh restarts from default row after release
// - host holds reset 200 ns, no access
// - host waits 200 ns release to select
// - host waits 400 ns fall to select
// - host should reload data after reset
// - soft reset gives standby and defaults
// - soft reset suspends refresh, resets row counter
// - standby within 400 ns of select rise
// - host should reload data after soft reset
// - host resets after shallow supply dip; host end has no supply input and resets only on HW_RESET_REQ_I
// - power-up init waits for reset release
`timescale 1ns/1ps
`default_nettype none
`include "prc_map.svh"
module prc_mem_end (
   input wire logic CLK_SYS_I,
   input wire logic RESET_I,
   prc_link_if.mem link,
   input wire logic SLEEP_REQ_I,
   input wire logic DEEP_DOWN_REQ_I,
   input wire logic CFG_WR_I,
   input wire logic [15:0] CFG_DATA_I,
   output logic [2:0] STATE_O,
   output logic READY_O,
   output logic REFRESH_ON_O,
   output logic ARRAY_VALID_O,
   output logic [15:0] CFG_O,
   output logic [12:0] REFRESH_ROW_O
);
   localparam int INIT_CYC = `PRC_POWERUP_INIT_TIME_CYC;
   localparam int SETTLE_CYC = `PRC_SOFT_RESET_SETTLE_CYC;
   prc_pkg::prc_pwr_t state_r, state_nxt;
   logic [15:0] cfg_r, cfg_nxt;
   logic [12:0] row_r, row_nxt;
   logic [15:0] cnt_r, cnt_nxt;
   logic valid_r, valid_nxt;
   logic refresh_r, refresh_nxt;
   logic ready_r, ready_nxt;
   logic sel_d_r;
   // command level seen while select was still low, so the rising edge can use it
   logic soft_d_r;
   logic sel_rise;
   assign sel_rise = link.select_n & ~sel_d_r;
   always_comb begin
      state_nxt = state_r;
      cfg_nxt = cfg_r;
      row_nxt = row_r;
      cnt_nxt = cnt_r;
      valid_nxt = valid_r;
      refresh_nxt = (state_r != prc_pkg::PRC_PWR_DEEP_DOWN);
      if (!link.reset_n) begin
         // pin reset overrides any activity, sleep or power down
         if (state_r == prc_pkg::PRC_PWR_INIT) begin
            // power-up init is held off until the pin is released
            state_nxt = prc_pkg::PRC_PWR_INIT;
         end else begin
            state_nxt = prc_pkg::PRC_PWR_HW_RESET;
         end
         cfg_nxt = `PRC_CFG_DEFAULT;
         row_nxt = `PRC_ROW_DEFAULT;
         refresh_nxt = 1'b0;
         valid_nxt = 1'b0;
         cnt_nxt = 16'h0000;
      end else begin
         if (refresh_nxt) begin
            row_nxt = row_r + 13'h0001;
         end
         case (state_r)
            prc_pkg::PRC_PWR_INIT: begin
               // init period only starts counting with reset high
               if (int'(cnt_r) >= INIT_CYC - 1) begin
                  state_nxt = prc_pkg::PRC_PWR_STANDBY;
                  valid_nxt = 1'b1;
               end else begin
                  cnt_nxt = cnt_r + 16'h0001;
               end
            end
            prc_pkg::PRC_PWR_HW_RESET: begin
               state_nxt = prc_pkg::PRC_PWR_STANDBY;
            end
            prc_pkg::PRC_PWR_STANDBY: begin
               if (!link.select_n) begin
                  state_nxt = prc_pkg::PRC_PWR_ACTIVE;
               end else if (DEEP_DOWN_REQ_I) begin
                  state_nxt = prc_pkg::PRC_PWR_DEEP_DOWN;
               end else if (SLEEP_REQ_I) begin
                  state_nxt = prc_pkg::PRC_PWR_HYBRID_SLEEP;
               end
            end
            prc_pkg::PRC_PWR_ACTIVE: begin
               if (CFG_WR_I) begin
                  cfg_nxt = CFG_DATA_I;
               end
               if (sel_rise && soft_d_r) begin
                  state_nxt = prc_pkg::PRC_PWR_SOFT_RESET;
                  cnt_nxt = 16'h0000;
                  cfg_nxt = `PRC_CFG_DEFAULT;
                  row_nxt = `PRC_ROW_DEFAULT;
                  refresh_nxt = 1'b0;
                  valid_nxt = 1'b0;
               end else if (sel_rise) begin
                  state_nxt = prc_pkg::PRC_PWR_STANDBY;
               end
            end
            prc_pkg::PRC_PWR_SOFT_RESET: begin
               refresh_nxt = 1'b0;
               row_nxt = `PRC_ROW_DEFAULT;
               if (int'(cnt_r) >= SETTLE_CYC - 2) begin
                  state_nxt = prc_pkg::PRC_PWR_STANDBY;
               end else begin
                  cnt_nxt = cnt_r + 16'h0001;
               end
            end
            prc_pkg::PRC_PWR_HYBRID_SLEEP,
            prc_pkg::PRC_PWR_DEEP_DOWN: begin
               if (!link.select_n) begin
                  state_nxt = prc_pkg::PRC_PWR_STANDBY;
               end
            end
            default: begin
               state_nxt = prc_pkg::PRC_PWR_STANDBY;
            end
         endcase
      end
      if (state_r == prc_pkg::PRC_PWR_DEEP_DOWN) begin
         valid_nxt = 1'b0;
      end
      ready_nxt = (state_nxt == prc_pkg::PRC_PWR_STANDBY) || (state_nxt == prc_pkg::PRC_PWR_ACTIVE);
   end
   always_ff @(posedge CLK_SYS_I) begin
      if (RESET_I) begin
         state_r <= prc_pkg::PRC_PWR_INIT;
         cfg_r <= `PRC_CFG_DEFAULT;
         row_r <= `PRC_ROW_DEFAULT;
         cnt_r <= 16'h0000;
         valid_r <= 1'b0;
         refresh_r <= 1'b0;
         ready_r <= 1'b0;
         sel_d_r <= 1'b1;
         soft_d_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cfg_r <= cfg_nxt;
         row_r <= row_nxt;
         cnt_r <= cnt_nxt;
         valid_r <= valid_nxt;
         refresh_r <= refresh_nxt;
         ready_r <= ready_nxt;
         sel_d_r <= link.select_n;
         soft_d_r <= link.soft_reset_cmd;
      end
   end
   assign STATE_O = state_r;
   assign READY_O = ready_r;
   assign REFRESH_ON_O = refresh_r;
   assign ARRAY_VALID_O = valid_r;
   assign CFG_O = cfg_r;
   assign REFRESH_ROW_O = row_r;
endmodule
`default_nettype wire

// *** prc_map.svh ***
// timing constants for the pseudo-static dram reset control link
`ifndef PRC_MAP_SVH
`define PRC_MAP_SVH
`define PRC_CLK_PERIOD_PS 8000
`define PRC_RESET_PULSE_MIN_NS 200
`define PRC_RESET_RELEASE_TO_SELECT_NS 200
`define PRC_RESET_FALL_TO_SELECT_NS 400
`define PRC_SOFT_RESET_SETTLE_NS 400
`define PRC_POWERUP_INIT_TIME_US 150
// least times round up, longest times round down
`define PRC_RESET_PULSE_MIN_CYC ((`PRC_RESET_PULSE_MIN_NS * 1000 + `PRC_CLK_PERIOD_PS - 1) / `PRC_CLK_PERIOD_PS)
`define PRC_RESET_RELEASE_TO_SELECT_CYC ((`PRC_RESET_RELEASE_TO_SELECT_NS * 1000 + `PRC_CLK_PERIOD_PS - 1) / `PRC_CLK_PERIOD_PS)
`define PRC_RESET_FALL_TO_SELECT_CYC ((`PRC_RESET_FALL_TO_SELECT_NS * 1000 + `PRC_CLK_PERIOD_PS - 1) / `PRC_CLK_PERIOD_PS)
`define PRC_SOFT_RESET_SETTLE_CYC ((`PRC_SOFT_RESET_SETTLE_NS * 1000) / `PRC_CLK_PERIOD_PS)
`define PRC_POWERUP_INIT_TIME_CYC ((`PRC_POWERUP_INIT_TIME_US * 1000000) / `PRC_CLK_PERIOD_PS)
`define PRC_CFG_DEFAULT 16'h8f1f
`define PRC_ROW_DEFAULT 13'h0000
`endif

// *** prc_pkg.sv ***
// types shared by the memory end, the assertions and the bench of the reset control link
package prc_pkg;
   typedef enum logic [2:0] {
      PRC_PWR_INIT,
      PRC_PWR_STANDBY,
      PRC_PWR_ACTIVE,
      PRC_PWR_HYBRID_SLEEP,
      PRC_PWR_DEEP_DOWN,
      PRC_PWR_HW_RESET,
      PRC_PWR_SOFT_RESET
   } prc_pwr_t;
endpackage

// *** prc_link_if.sv ***
// link between host controller and memory reset logic
`timescale 1ns/1ps
`default_nettype none
interface prc_link_if;
   logic reset_n;
   logic select_n;
   logic soft_reset_cmd;
   modport host (output reset_n, output select_n, output soft_reset_cmd);
   modport mem (input reset_n, input select_n, input soft_reset_cmd);
endinterface
`default_nettype wire

// *** prc_host_end.sv ***
// host-side reset pin and chip select sequencing
`timescale 1ns/1ps
`default_nettype none
`include "prc_map.svh"
module prc_host_end (
   input wire logic CLK_SYS_I,
   input wire logic RESET_I,
   prc_link_if.host link,
   input wire logic HW_RESET_REQ_I,
   input wire logic SOFT_RESET_REQ_I,
   input wire logic ACCESS_REQ_I,
   output logic BUSY_O,
   output logic DATA_LOST_O
);
   localparam int PULSE_CYC = `PRC_RESET_PULSE_MIN_CYC;
   localparam int REL_CYC = `PRC_RESET_RELEASE_TO_SELECT_CYC;
   localparam int FALL_CYC = `PRC_RESET_FALL_TO_SELECT_CYC;
   localparam int SETTLE_CYC = `PRC_SOFT_RESET_SETTLE_CYC;
   typedef enum logic [2:0] {H_IDLE, H_RST_LOW, H_RST_WAIT, H_SEL, H_SOFT_SEL, H_SOFT_WAIT} prc_host_st_t;
   prc_host_st_t st_r, st_nxt;
   logic [7:0] cnt_r, cnt_nxt;
   logic [7:0] fall_r, fall_nxt;
   logic rst_n_r, rst_n_nxt;
   logic sel_n_r, sel_n_nxt;
   logic soft_r, soft_nxt;
   logic lost_r, lost_nxt;
   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r + 8'h01;
      fall_nxt = (fall_r == 8'hff) ? fall_r : fall_r + 8'h01;
      rst_n_nxt = rst_n_r;
      sel_n_nxt = 1'b1;
      soft_nxt = 1'b0;
      lost_nxt = lost_r & ~ACCESS_REQ_I;
      case (st_r)
         H_IDLE: begin
            cnt_nxt = 8'h00;
            if (HW_RESET_REQ_I) begin
               st_nxt = H_RST_LOW;
               rst_n_nxt = 1'b0;
               fall_nxt = 8'h00;
            end else if (SOFT_RESET_REQ_I) begin
               st_nxt = H_SOFT_SEL;
               sel_n_nxt = 1'b0;
               soft_nxt = 1'b1;
            end else if (ACCESS_REQ_I) begin
               st_nxt = H_SEL;
               sel_n_nxt = 1'b0;
            end
         end
         H_RST_LOW: begin
            if (int'(cnt_r) >= PULSE_CYC - 1) begin
               st_nxt = H_RST_WAIT;
               rst_n_nxt = 1'b1;
               cnt_nxt = 8'h00;
            end
         end
         H_RST_WAIT: begin
            // both release and fall intervals must pass before select
            if (int'(cnt_r) >= REL_CYC - 1 && int'(fall_r) >= FALL_CYC - 1) begin
               st_nxt = H_IDLE;
               lost_nxt = 1'b1;
            end
         end
         H_SEL: begin
            st_nxt = H_IDLE;
         end
         H_SOFT_SEL: begin
            st_nxt = H_SOFT_WAIT;
            cnt_nxt = 8'h00;
         end
         H_SOFT_WAIT: begin
            if (int'(cnt_r) >= SETTLE_CYC - 1) begin
               st_nxt = H_IDLE;
               lost_nxt = 1'b1;
            end
         end
         default: begin
            st_nxt = H_IDLE;
         end
      endcase
   end
   always_ff @(posedge CLK_SYS_I) begin
      if (RESET_I) begin
         st_r <= H_IDLE;
         cnt_r <= 8'h00;
         fall_r <= 8'hff;
         rst_n_r <= 1'b1;
         sel_n_r <= 1'b1;
         soft_r <= 1'b0;
         lost_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         fall_r <= fall_nxt;
         rst_n_r <= rst_n_nxt;
         sel_n_r <= sel_n_nxt;
         soft_r <= soft_nxt;
         lost_r <= lost_nxt;
      end
   end
   assign link.reset_n = rst_n_r;
   assign link.select_n = sel_n_r;
   assign link.soft_reset_cmd = soft_r;
   assign BUSY_O = (st_r != H_IDLE);
   assign DATA_LOST_O = lost_r;
endmodule
`default_nettype wire

// *** prc_link_assertions.sv ***
// concurrent checks on the reset control link and the memory end
`timescale 1ns/1ps
`default_nettype none
`include "prc_map.svh"
module prc_link_assertions (
   input wire logic CLK_SYS_I,
   input wire logic RESET_I,
   input wire logic reset_n,
   input wire logic select_n,
   input wire logic soft_reset_cmd,
   input wire logic [2:0] STATE_O,
   input wire logic REFRESH_ON_O,
   input wire logic ARRAY_VALID_O,
   input wire logic [15:0] CFG_O,
   input wire logic [12:0] REFRESH_ROW_O
);
   default clocking @(posedge CLK_SYS_I); endclocking
   default disable iff (RESET_I);
   logic prev_r, prev_nxt;
   logic [7:0] fall_r, fall_nxt, rise_r, rise_nxt;
   // cycles since the reset pin fell and since it rose, saturating
   always_comb begin
      prev_nxt = reset_n;
      fall_nxt = (!reset_n && prev_r) ? 8'h01 : fall_r + {7'h00, fall_r != 8'hff};
      rise_nxt = !reset_n ? 8'h00 : rise_r + {7'h00, rise_r != 8'hff};
   end
   always_ff @(posedge CLK_SYS_I) begin
      if (RESET_I) begin
         prev_r <= 1'b1;
         fall_r <= 8'hff;
         rise_r <= 8'hff;
      end else begin
         prev_r <= prev_nxt;
         fall_r <= fall_nxt;
         rise_r <= rise_nxt;
      end
   end
   hw_reset_state_a: assert property (!reset_n |=> STATE_O == (($past(STATE_O) == prc_pkg::PRC_PWR_INIT)
      ? prc_pkg::PRC_PWR_INIT : prc_pkg::PRC_PWR_HW_RESET))
      else $error("state not hardware reset after pin low");
   hw_cfg_default_a: assert property (!reset_n |=> CFG_O == `PRC_CFG_DEFAULT)
      else $error("config not default during hardware reset");
   refresh_halt_a: assert property (!reset_n |=> !REFRESH_ON_O && !ARRAY_VALID_O)
      else $error("refresh running during hardware reset");
   release_standby_a: assert property ($rose(reset_n) |=> STATE_O == (($past(STATE_O) == prc_pkg::PRC_PWR_INIT)
      ? prc_pkg::PRC_PWR_INIT : prc_pkg::PRC_PWR_STANDBY))
      else $error("no standby after pin release");
   row_default_a: assert property (!reset_n |=> REFRESH_ROW_O == `PRC_ROW_DEFAULT)
      else $error("refresh row not default during reset");
   pulse_width_a: assert property ($rose(reset_n) |-> fall_r >= `PRC_RESET_PULSE_MIN_CYC)
      else $error("reset pulse too short");
   select_spacing_a: assert property ($fell(select_n) |-> rise_r >= `PRC_RESET_RELEASE_TO_SELECT_CYC
      && fall_r >= `PRC_RESET_FALL_TO_SELECT_CYC)
      else $error("select too soon after reset");
   soft_settle_a: assert property ($rose(select_n) && $past(soft_reset_cmd)
      |-> ##[1:50] STATE_O == prc_pkg::PRC_PWR_STANDBY)
      else $error("soft reset did not settle in time");
   soft_suspend_a: assert property ($past(STATE_O) == prc_pkg::PRC_PWR_SOFT_RESET
      && STATE_O == prc_pkg::PRC_PWR_SOFT_RESET |-> !REFRESH_ON_O && CFG_O == `PRC_CFG_DEFAULT)
      else $error("refresh or config wrong during soft reset");
endmodule
`default_nettype wire

// *** testbench.sv ***
// self-checking bench for both ends of the reset control link
`timescale 1ns/1ps
`default_nettype none
`include "prc_map.svh"
module testbench;
   logic clk, rst, hw_req, soft_req, acc_req, sleep_req, deep_req, cfg_wr;
   logic [15:0] cfg_data, cfg;
   logic busy, lost, ready, refresh_on, valid;
   logic [2:0] state;
   logic [12:0] row;
   int errors = 0;
   int comparisons = 0;
   int low_cnt;
   prc_link_if lnk();
   prc_host_end u_prc_host_end (.CLK_SYS_I(clk), .RESET_I(rst), .link(lnk), .HW_RESET_REQ_I(hw_req),
      .SOFT_RESET_REQ_I(soft_req), .ACCESS_REQ_I(acc_req), .BUSY_O(busy), .DATA_LOST_O(lost));
   prc_mem_end u_prc_mem_end (.CLK_SYS_I(clk), .RESET_I(rst), .link(lnk), .SLEEP_REQ_I(sleep_req),
      .DEEP_DOWN_REQ_I(deep_req), .CFG_WR_I(cfg_wr), .CFG_DATA_I(cfg_data), .STATE_O(state),
      .READY_O(ready), .REFRESH_ON_O(refresh_on), .ARRAY_VALID_O(valid), .CFG_O(cfg), .REFRESH_ROW_O(row));
   prc_link_assertions u_prc_link_assertions (.CLK_SYS_I(clk), .RESET_I(rst), .reset_n(lnk.reset_n),
      .select_n(lnk.select_n), .soft_reset_cmd(lnk.soft_reset_cmd), .STATE_O(state),
      .REFRESH_ON_O(refresh_on), .ARRAY_VALID_O(valid), .CFG_O(cfg), .REFRESH_ROW_O(row));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic print_verdict;
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // advance to just after the next edge, counting reset pin low cycles
   task automatic tick;
      @(posedge clk);
      #1;
      if (lnk.reset_n === 1'b0)
         low_cnt++;
   endtask
   task automatic wait_idle;
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 300) begin
         tick();
         n++;
      end
      check({15'h0000, n < 300}, 16'h0001);
   endtask
   task automatic init_delay;
      repeat (100) tick();
      check({13'h0000, state}, {13'h0000, prc_pkg::PRC_PWR_INIT});
      check({15'h0000, ready}, 16'h0000);
      repeat (`PRC_POWERUP_INIT_TIME_CYC) tick();
      check({13'h0000, state}, {13'h0000, prc_pkg::PRC_PWR_STANDBY});
   endtask
   task automatic hw_exit(input logic deep, input logic [2:0] lp);
      @(posedge clk);
      sleep_req <= !deep;
      deep_req <= deep;
      repeat (5) @(posedge clk);
      sleep_req <= 1'b0;
      deep_req <= 1'b0;
      hw_req <= 1'b1;
      #1;
      check({13'h0000, state}, {13'h0000, lp});
      @(posedge clk);
      hw_req <= 1'b0;
      #1;
      // the pin is already low in the cycle that follows the request edge
      low_cnt = (lnk.reset_n === 1'b0) ? 1 : 0;
      repeat (10) tick();
      check({13'h0000, state}, {13'h0000, prc_pkg::PRC_PWR_HW_RESET});
      check({14'h0000, refresh_on, valid}, 16'h0000);
      check({15'h0000, lnk.select_n}, 16'h0001);
      wait_idle();
      check({15'h0000, low_cnt >= `PRC_RESET_PULSE_MIN_CYC}, 16'h0001);
      check({13'h0000, state}, {13'h0000, prc_pkg::PRC_PWR_STANDBY});
      check(cfg, `PRC_CFG_DEFAULT);
      check({15'h0000, lost}, 16'h0001);
   endtask
   task automatic soft_reset;
      @(posedge clk);
      acc_req <= 1'b1;
      @(posedge clk);
      acc_req <= 1'b0;
      @(posedge clk);
      // config write must be seen while the memory end is active
      cfg_wr <= 1'b1;
      cfg_data <= 16'h1234;
      @(posedge clk);
      cfg_wr <= 1'b0;
      wait_idle();
      tick();
      check(cfg, 16'h1234);
      check({15'h0000, lost}, 16'h0000);
      @(posedge clk);
      soft_req <= 1'b1;
      @(posedge clk);
      soft_req <= 1'b0;
      wait_idle();
      repeat (60) tick();
      check({13'h0000, state}, {13'h0000, prc_pkg::PRC_PWR_STANDBY});
      check(cfg, `PRC_CFG_DEFAULT);
      check({15'h0000, refresh_on}, 16'h0001);
      check({15'h0000, lost}, 16'h0001);
   endtask
   initial begin
      repeat (40000) @(posedge clk);
      errors++;
      print_verdict();
   end
   initial begin
      {rst, hw_req, soft_req, acc_req, sleep_req, deep_req, cfg_wr} = 7'h40;
      cfg_data = 16'h0000;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      init_delay();
      hw_exit(1'b0, prc_pkg::PRC_PWR_HYBRID_SLEEP);
      hw_exit(1'b1, prc_pkg::PRC_PWR_DEEP_DOWN);
      soft_reset();
      print_verdict();
   end
endmodule
`default_nettype wire
